// ==== inc/sso_consts.vh ====
// constants for the servo status output block
`ifndef SSO_CONSTS_VH
`define SSO_CONSTS_VH
// setup parameter bit positions
`define SSO_P1_SHARED_SEL_BIT 4
`define SSO_P2_DIR_SWAP_BIT 0
`define SSO_P2_INPUT_SEL_BIT 2
// alarm code shown while no fault is latched
`define SSO_ALARM_CODE_IDLE 3'h7
// power-up processing time in microseconds and its cycle count at 40 MHz
`define SSO_CLK_MHZ 40
`define SSO_POWERUP_US 6000000
`define SSO_POWERUP_CYC (`SSO_POWERUP_US * `SSO_CLK_MHZ)
// encoder divider reset value, pulses per revolution
`define SSO_DIV_RATE_RST 12'h3e8
`define SSO_ENC_PPR_RST 12'h800
`endif

// ==== design/sso_enc_divider.v ====
// encoder pulse divider: re-emits step and direction scaled by out_ppr/in_ppr
`timescale 1ns/1ps
`default_nettype none
module sso_enc_divider #(
  parameter W = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire step_i,
  input wire dir_i,
  input wire [W-1:0] in_ppr_i,
  input wire [W-1:0] out_ppr_i,
  output reg step_o,
  output reg dir_o
);
  // ---------------------------------------------------------------
  // rate accumulator
  // ---------------------------------------------------------------
  // each input edge adds out_ppr; overflow past in_ppr gives one output edge,
  // so output edges per rev = out_ppr when out_ppr <= in_ppr
  reg [W:0] acc_r;
  wire [W:0] sum = acc_r + {1'b0, out_ppr_i};
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= {(W+1){1'b0}};
      step_o <= 1'b0;
      dir_o <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (step_i) begin
        dir_o <= dir_i;
        if (sum >= {1'b0, in_ppr_i}) begin
          acc_r <= sum - {1'b0, in_ppr_i};
          step_o <= 1'b1;
        end else begin
          acc_r <= sum;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/sso_status_out.v ====
// status, alarm and divided encoder outputs of a pulse-train servo driver
// Functional notes
// - in-position on while residual error count below configured range
// - in-position not qualified by motion; may stay on while moving
// - shared output is rotation detect when setup bit 4 clear
// - bit 4 set with both limits: flag torque at smaller limit
// - on fault, alarm-ready drops and fault code is presented
// - alarm-ready off from power-on until power-up processing done
// - fault cause is a three-bit code on three lines
// - encoder A, B, Z regenerated as divided quadrature pulses
// - brake interlock timed from three brake timing parameters
// - direction swap via ground strap or setup two bit 0, same effect
// - reversed direction swaps output phasing, B leads on forward
// - U, V, W, Z sensor info recovered serially from S-phase input
// - with setup two bit 2 clear, inputs act as current limits
// - alarm reset input clears latched alarm once the fault input is low
`timescale 1ns/1ps
`default_nettype none
`include "sso_consts.vh"
module sso_status_out #(
  parameter EW = 16,
  parameter SW = 12,
  parameter TW = 10,
  parameter BW = 16,
  parameter CW = 12,
  parameter [31:0] POWERUP_CYC = `SSO_POWERUP_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] setup_param_one_i,
  input wire [15:0] setup_param_two_i,
  input wire [EW-1:0] pos_error_abs_i,
  input wire [EW-1:0] in_position_range_i,
  input wire [SW-1:0] motor_speed_abs_i,
  input wire [SW-1:0] rotation_detect_speed_i,
  input wire [TW-1:0] torque_abs_i,
  input wire torque_dir_rev_i,
  input wire [TW-1:0] fwd_external_current_limit_i,
  input wire [TW-1:0] rev_external_current_limit_i,
  input wire [TW-1:0] fwd_torque_limit_i,
  input wire [TW-1:0] rev_torque_limit_i,
  input wire forward_current_limit_in_i,
  input wire reverse_current_limit_in_i,
  input wire fault_i,
  input wire [2:0] fault_code_i,
  input wire alarm_reset_in_i,
  input wire servo_on_i,
  input wire [BW-1:0] brake_timing_a_i,
  input wire [BW-1:0] brake_timing_b_i,
  input wire [BW-1:0] brake_timing_c_i,
  input wire [CW-1:0] encoder_divider_rate_i,
  input wire [CW-1:0] encoder_ppr_i,
  input wire enc_a_i,
  input wire enc_b_i,
  input wire enc_s_i,
  input wire dir_swap_strap_n_i,
  output reg in_position_out_o,
  output reg shared_flag_out_o,
  output reg current_limit_active_o,
  output reg brake_interlock_out_o,
  output reg alarm_ready_out_o,
  output reg [2:0] alarm_code_o,
  output reg enc_out_a_o,
  output reg enc_out_b_o,
  output reg enc_out_z_o,
  output reg [2:0] sensor_uvw_o,
  output reg sensor_z_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [4:0] s1_r;
  reg [4:0] s2_r;
  // fault and limit inputs come from logic on this clock and skip these stages
  always @(posedge clk_i) begin
    if (rst_i) begin
      // idle pin levels: strap open, no alarm reset, encoder in state 00,
      // so the edge detector sees no false step once reset lets go
      s1_r <= 5'h10;
      s2_r <= 5'h10;
    end else begin
      s1_r <= {dir_swap_strap_n_i, alarm_reset_in_i, enc_s_i, enc_b_i, enc_a_i};
      s2_r <= s1_r;
    end
  end
  wire a_s = s2_r[0];
  wire b_s = s2_r[1];
  wire s_s = s2_r[2];
  wire rst_req = s2_r[3];
  // strap and parameter bit act the same way
  wire dir_swap = ~s2_r[4] | setup_param_two_i[`SSO_P2_DIR_SWAP_BIT];

  // ---------------------------------------------------------------
  // in-position and shared flag
  // ---------------------------------------------------------------
  // no speed qualification on purpose: a large range keeps it on in motion
  wire inpos_nxt = pos_error_abs_i < in_position_range_i;
  wire lim_mode = ~setup_param_two_i[`SSO_P2_INPUT_SEL_BIT];
  wire [TW-1:0] ext_lim = torque_dir_rev_i ? rev_external_current_limit_i
                                           : fwd_external_current_limit_i;
  wire [TW-1:0] int_lim = torque_dir_rev_i ? rev_torque_limit_i : fwd_torque_limit_i;
  wire [TW-1:0] eff_lim = (ext_lim < int_lim) ? ext_lim : int_lim;
  wire lim_req = torque_dir_rev_i ? reverse_current_limit_in_i : forward_current_limit_in_i;
  wire lim_on = lim_mode & lim_req;
  wire current_limit_reached_out_nxt = lim_mode & forward_current_limit_in_i & reverse_current_limit_in_i &
                    (torque_abs_i >= eff_lim);
  wire rotation_detected_out_nxt = motor_speed_abs_i >= rotation_detect_speed_i;
  wire shared_nxt = setup_param_one_i[`SSO_P1_SHARED_SEL_BIT] ? current_limit_reached_out_nxt : rotation_detected_out_nxt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_position_out_o <= 1'b0;
      shared_flag_out_o <= 1'b0;
      current_limit_active_o <= 1'b0;
    end else begin
      in_position_out_o <= inpos_nxt;
      shared_flag_out_o <= shared_nxt;
      current_limit_active_o <= lim_on;
    end
  end

  // ---------------------------------------------------------------
  // power-up and alarm latch
  // ---------------------------------------------------------------
  reg [31:0] pu_cnt_r;
  reg pu_done_r;
  reg alarm_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pu_cnt_r <= 32'h0;
      pu_done_r <= 1'b0;
      alarm_r <= 1'b0;
      alarm_ready_out_o <= 1'b0;
      alarm_code_o <= `SSO_ALARM_CODE_IDLE;
    end else begin
      if (!pu_done_r) begin
        pu_cnt_r <= pu_cnt_r + 32'h1;
        if (pu_cnt_r >= POWERUP_CYC - 32'h1)
          pu_done_r <= 1'b1;
      end
      // a fault in the reset cycle wins over the reset
      // limitation: a second fault is not shown until the first is cleared
      if (fault_i && !alarm_r) begin
        alarm_r <= 1'b1;
        alarm_code_o <= fault_code_i;
      end else if (rst_req && alarm_r && !fault_i) begin
        alarm_r <= 1'b0;
        alarm_code_o <= `SSO_ALARM_CODE_IDLE;
      end
      alarm_ready_out_o <= pu_done_r & ~alarm_r & ~fault_i;
    end
  end

  // ---------------------------------------------------------------
  // brake interlock
  // ---------------------------------------------------------------
  // a: delay from servo off to brake engage below rotation-detect speed; b: same delay at or above it;
  // c: wait after servo on before releasing brake
  // a latched alarm always drives the state machine towards an engaged brake
  localparam ST_ENG = 3'b001;
  localparam ST_REL = 3'b010;
  localparam ST_OFF = 3'b100;
  reg [2:0] bst_r;
  reg [BW-1:0] bcnt_r;
  wire [BW-1:0] bto = (motor_speed_abs_i >= rotation_detect_speed_i) ?
                      brake_timing_b_i : brake_timing_a_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      bst_r <= ST_ENG;
      bcnt_r <= {BW{1'b0}};
      brake_interlock_out_o <= 1'b0;
    end else begin
      case (bst_r)
        ST_ENG: begin
          brake_interlock_out_o <= 1'b0;
          if (!servo_on_i || alarm_r)
            bcnt_r <= {BW{1'b0}};
          else if (bcnt_r >= brake_timing_c_i) begin
            bst_r <= ST_REL;
            brake_interlock_out_o <= 1'b1;
          end else
            bcnt_r <= bcnt_r + {{(BW-1){1'b0}}, 1'b1};
        end
        ST_REL: begin
          bcnt_r <= {BW{1'b0}};
          if (!servo_on_i || alarm_r)
            bst_r <= ST_OFF;
        end
        ST_OFF: begin
          if (servo_on_i && !alarm_r) begin
            bst_r <= ST_REL;
            bcnt_r <= {BW{1'b0}};
          end else if (bcnt_r >= bto) begin
            bst_r <= ST_ENG;
            brake_interlock_out_o <= 1'b0;
            bcnt_r <= {BW{1'b0}};
          end else
            bcnt_r <= bcnt_r + {{(BW-1){1'b0}}, 1'b1};
        end
        default: bst_r <= ST_ENG;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // quadrature decode, S-phase demux
  // ---------------------------------------------------------------
  reg a_d_r;
  reg b_d_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
    end else begin
      a_d_r <= a_s;
      b_d_r <= b_s;
    end
  end
  wire qstep = (a_s ^ a_d_r) | (b_s ^ b_d_r);
  // forward when a leads b
  wire qfwd = a_s ^ b_d_r;
  // S-phase read per quadrature state: 00 -> U, 01 -> V, 11 -> W, 10 -> Z
  always @(posedge clk_i) begin
    if (rst_i) begin
      sensor_uvw_o <= 3'h0;
      sensor_z_o <= 1'b0;
    end else begin
      case ({a_s, b_s})
        2'b00: sensor_uvw_o[0] <= s_s;
        2'b01: sensor_uvw_o[1] <= s_s;
        2'b11: sensor_uvw_o[2] <= s_s;
        default: sensor_z_o <= s_s;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // divided quadrature output
  // ---------------------------------------------------------------
  // limitation: the divider rate must not exceed the encoder count per rev
  wire dstep;
  wire ddir;
  sso_enc_divider #(.W(CW)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(qstep),
    .dir_i(qfwd),
    .in_ppr_i(encoder_ppr_i),
    .out_ppr_i(encoder_divider_rate_i),
    .step_o(dstep),
    .dir_o(ddir)
  );
  reg [1:0] ph_r;
  // index period is four output states per divided pulse; it must fit in CW bits
  reg [CW-1:0] zcnt_r;
  // swapping the phase order keeps host wiring valid after reversal
  wire up = ddir ^ dir_swap;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ph_r <= 2'h0;
      zcnt_r <= {CW{1'b0}};
      enc_out_a_o <= 1'b0;
      enc_out_b_o <= 1'b0;
      enc_out_z_o <= 1'b0;
    end else begin
      if (dstep) begin
        ph_r <= up ? ph_r + 2'h1 : ph_r - 2'h1;
        if (up)
          zcnt_r <= (zcnt_r >= {encoder_divider_rate_i[CW-3:0], 2'b00} - 1'b1) ?
                    {CW{1'b0}} : zcnt_r + {{(CW-1){1'b0}}, 1'b1};
        else
          zcnt_r <= (zcnt_r == {CW{1'b0}}) ?
                    {encoder_divider_rate_i[CW-3:0], 2'b00} - 1'b1 :
                    zcnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
      // stepping up walks a,b through 00,10,11,01, so a leads b; the swap
      // turns the count round and b then leads for the same motion
      enc_out_a_o <= ph_r[1] ^ ph_r[0];
      enc_out_b_o <= ph_r[1];
      enc_out_z_o <= (zcnt_r == {CW{1'b0}});
    end
  end
endmodule
`default_nettype wire

// ==== tb/sso_status_asserts.sv ====
// assertion checker for the servo status output block
`timescale 1ns/1ps
`default_nettype none
module sso_status_asserts #(
  parameter [31:0] POWERUP_CYC = 32'h0000000a
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] setup_param_one_i,
  input wire logic [15:0] setup_param_two_i,
  input wire logic [15:0] pos_error_abs_i,
  input wire logic [15:0] in_position_range_i,
  input wire logic [11:0] motor_speed_abs_i,
  input wire logic [11:0] rotation_detect_speed_i,
  input wire logic [9:0] torque_abs_i,
  input wire logic torque_dir_rev_i,
  input wire logic [9:0] fwd_external_current_limit_i,
  input wire logic [9:0] rev_external_current_limit_i,
  input wire logic [9:0] fwd_torque_limit_i,
  input wire logic [9:0] rev_torque_limit_i,
  input wire logic forward_current_limit_in_i,
  input wire logic reverse_current_limit_in_i,
  input wire logic fault_i,
  input wire logic [2:0] fault_code_i,
  input wire logic alarm_reset_in_i,
  input wire logic servo_on_i,
  input wire logic in_position_out_o,
  input wire logic shared_flag_out_o,
  input wire logic brake_interlock_out_o,
  input wire logic alarm_ready_out_o,
  input wire logic [2:0] alarm_code_o
);
  logic [31:0] pu_cnt_r;
  logic [9:0] lim;
  // saturating, so a long run never wraps back into the power-up window
  always_ff @(posedge clk_i) begin
    if (rst_i) pu_cnt_r <= 32'h0;
    else if (pu_cnt_r != 32'hffffffff) pu_cnt_r <= pu_cnt_r + 32'h1;
  end
  assign lim = torque_dir_rev_i ?
    (rev_external_current_limit_i < rev_torque_limit_i ? rev_external_current_limit_i :
      rev_torque_limit_i) :
    (fwd_external_current_limit_i < fwd_torque_limit_i ? fwd_external_current_limit_i :
      fwd_torque_limit_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_inpos_level: assert property (!$past(rst_i) |->
    in_position_out_o == $past(pos_error_abs_i < in_position_range_i)) else $error("in-position");
  a_rot_flag: assert property (!$past(rst_i) && !$past(setup_param_one_i[4]) |->
    shared_flag_out_o == $past(motor_speed_abs_i >= rotation_detect_speed_i)) else $error("rot");
  a_limit_flag: assert property (!$past(rst_i) && $past(setup_param_one_i[4] &&
    forward_current_limit_in_i && reverse_current_limit_in_i && !setup_param_two_i[2]) |->
    shared_flag_out_o == $past(torque_abs_i >= lim)) else $error("limit flag");
  a_fault_latch: assert property (fault_i && alarm_ready_out_o |=>
    !alarm_ready_out_o && alarm_code_o == $past(fault_code_i)) else $error("fault latch");
  a_code_idle: assert property (alarm_ready_out_o |->
    alarm_code_o == 3'h7) else $error("idle code");
  a_code_hold: assert property (!$past(rst_i) && $changed(alarm_code_o) &&
    alarm_code_o != 3'h7 |-> $past(fault_i) && $past(alarm_code_o) == 3'h7) else $error("code");
  a_powerup_off: assert property (pu_cnt_r < POWERUP_CYC |->
    !alarm_ready_out_o) else $error("ready early");
  a_reset_clear: assert property ((alarm_reset_in_i && !fault_i)[*4] ##0
    pu_cnt_r > POWERUP_CYC + 4 |-> ##[0:3] alarm_ready_out_o) else $error("no clear");
  a_brake_cause: assert property ($rose(brake_interlock_out_o) |->
    $past(servo_on_i)) else $error("brake");
endmodule
bind sso_status_out sso_status_asserts #(.POWERUP_CYC(POWERUP_CYC)) i_chk (.clk_i, .rst_i,
  .setup_param_one_i, .setup_param_two_i, .pos_error_abs_i, .in_position_range_i,
  .motor_speed_abs_i, .rotation_detect_speed_i, .torque_abs_i, .torque_dir_rev_i,
  .fwd_external_current_limit_i, .rev_external_current_limit_i, .fwd_torque_limit_i,
  .rev_torque_limit_i, .forward_current_limit_in_i, .reverse_current_limit_in_i, .fault_i,
  .fault_code_i, .alarm_reset_in_i, .servo_on_i, .in_position_out_o, .shared_flag_out_o,
  .brake_interlock_out_o, .alarm_ready_out_o, .alarm_code_o);
`default_nettype wire

// ==== tb/sso_enc_model.sv ====
// motor encoder model: quadrature a/b with sensor phases carried on s
`timescale 1ns/1ps
`default_nettype none
module sso_enc_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic [3:0] uvwz_i,
  output logic a_o,
  output logic b_o,
  output logic s_o
);
  logic [1:0] ph_r = 2'h0;
  // one phase per step keeps a and b from ever changing together
  always @(posedge clk_i) begin
    if (step_i) ph_r <= ph_r + 2'h1;
  end
  always_comb begin
    a_o = ph_r[1] ^ ph_r[0];
    b_o = ph_r[1];
    case ({a_o, b_o})
      2'b00: s_o = uvwz_i[3];
      2'b01: s_o = uvwz_i[2];
      2'b11: s_o = uvwz_i[1];
      default: s_o = uvwz_i[0];
    endcase
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the servo status output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] lf = 32'h00005f2a;
  logic [15:0] p1 = 16'h0, p2 = 16'h0, err = 16'h0, rng = 16'h0;
  logic [11:0] spd = 12'h0, det = 12'h0;
  logic [9:0] tq = 10'h0, fe = 10'h0, re = 10'h0, ft = 10'h0, rt = 10'h0;
  logic [3:0] uvwz = 4'h0;
  logic [2:0] fc = 3'h0, code, uvw;
  logic tdir = 1'b0, fl = 1'b0, rl = 1'b0, flt = 1'b0, ars = 1'b0, son = 1'b0, step = 1'b0;
  logic strap_n = 1'b1, pa = 1'b0, pb = 1'b0, ea, eb, es, ip, sh, brk, rdy, za, zb, sz, zo, cla;
  logic [15:0] bta = 16'h0004, btb = 16'h0004, btc = 16'h0004;
  int failures = 0, total_checks = 0, fw = 0, bw = 0, n;
  sso_status_out #(.POWERUP_CYC(32'h0000000a)) i_dut (.clk_i, .rst_i,
    .setup_param_one_i(p1), .setup_param_two_i(p2), .pos_error_abs_i(err),
    .in_position_range_i(rng), .motor_speed_abs_i(spd), .rotation_detect_speed_i(det),
    .torque_abs_i(tq), .torque_dir_rev_i(tdir), .fwd_external_current_limit_i(fe),
    .rev_external_current_limit_i(re), .fwd_torque_limit_i(ft), .rev_torque_limit_i(rt),
    .forward_current_limit_in_i(fl), .reverse_current_limit_in_i(rl), .fault_i(flt),
    .fault_code_i(fc), .alarm_reset_in_i(ars), .servo_on_i(son),
    .brake_timing_a_i(bta), .brake_timing_b_i(btb), .brake_timing_c_i(btc),
    .encoder_divider_rate_i(12'h008), .encoder_ppr_i(12'h010), .enc_a_i(ea), .enc_b_i(eb),
    .enc_s_i(es), .dir_swap_strap_n_i(strap_n), .in_position_out_o(ip),
    .shared_flag_out_o(sh), .current_limit_active_o(cla), .brake_interlock_out_o(brk),
    .alarm_ready_out_o(rdy), .alarm_code_o(code), .enc_out_a_o(za), .enc_out_b_o(zb),
    .enc_out_z_o(zo), .sensor_uvw_o(uvw), .sensor_z_o(sz));
  sso_enc_model i_enc (.clk_i, .step_i(step), .uvwz_i(uvwz), .a_o(ea), .b_o(eb), .s_o(es));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // an output step is forward when a leads b
  always @(posedge clk_i) begin
    if (za !== pa || zb !== pb) begin
      if ((za != pa) == (za != zb)) fw++;
      else bw++;
    end
    pa = za;
    pb = zb;
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [9:0] mn(input logic [9:0] x, input logic [9:0] y);
    return x < y ? x : y;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wt(input int k);
    cyc(k);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst_i <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      lf = nx(lf);
      err <= lf[15:0];
      rng <= (i % 3 == 0) ? lf[15:0] : lf[31:16];
      spd <= lf[11:0];
      det <= (i % 3 == 1) ? lf[11:0] : lf[27:16];
      {tdir, fl, rl} <= lf[30:28];
      wt(2);
      chk("in_position", err < rng, ip);
      chk("current_limit_active", tdir ? rl : fl, cla);
      chk("rotation_detected", spd >= det, sh);
      cyc(1);
    end
    $display("test flags done");
    p1 <= 16'h0010;
    fl <= 1'b1;
    rl <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      lf = nx(lf);
      {tdir, tq, fe} <= lf[20:0];
      lf = nx(lf);
      {ft, rt, re} <= lf[29:0];
      wt(2);
      chk("current_limit", tq >= (tdir ? mn(re, rt) : mn(fe, ft)), sh);
      cyc(1);
    end
    $display("test limit done");
    chk("alarm_ready_init", 1, rdy);
    for (int c = 0; c < 7; c++) begin
      @(posedge clk_i);
      flt <= 1'b1;
      fc <= c[2:0];
      wt(2);
      chk("alarm_ready", 0, rdy);
      chk("alarm_code", c, code);
      cyc(1);
      fc <= c[2:0] + 3'h1;
      ars <= 1'b1;
      wt(6);
      chk("alarm_code_held", c, code);
      chk("alarm_reset_refused", 0, rdy);
      cyc(1);
      flt <= 1'b0;
      wt(6);
      chk("alarm_cleared", 1, rdy);
      chk("alarm_code_idle", 7, code);
      cyc(1);
      ars <= 1'b0;
    end
    $display("test alarm done");
    spd <= 12'h0;
    son <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      n = 0;
      while (brk !== !s[0] && n < 40) begin
        wt(1);
        n++;
      end
      chk("brake_delay", 1, n >= 4 && n < 40);
      cyc(1);
      son <= 1'b0;
    end
    $display("test brake done");
    for (int m = 0; m < 3; m++) begin
      strap_n <= (m != 1);
      p2 <= {15'h0, m == 2};
      lf = nx(lf);
      uvwz <= lf[3:0];
      cyc(10);
      fw = 0;
      bw = 0;
      repeat (32) begin
        step <= 1'b1;
        cyc(1);
        step <= 1'b0;
        cyc(7);
      end
      wt(1);
      chk("fwd_steps", m == 0 ? 16 : 0, fw);
      chk("rev_steps", m == 0 ? 0 : 16, bw);
      chk("sensor_uvwz", uvwz, {uvw[0], uvw[1], uvw[2], sz});
      chk("index_pulse", m == 1, zo);
      cyc(1);
    end
    $display("test encoder done");
    tally_and_finish();
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
